// ==== two_wire_pkg.sv ====
// Constants for the master two-wire serial controller
package two_wire_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_CTRL   = 8'he1;
    localparam logic [7:0]  IDX_DATA   = 8'he2;
    localparam logic [7:0]  IDX_STAT   = 8'hf0;
    localparam logic [7:0]  IDX_MASK   = 8'hf1;
    localparam int unsigned ADDR_W     = 12;
    localparam logic [11:0] A_CTRL     = 12'(IDX_CTRL * 4);
    localparam logic [11:0] A_DATA     = 12'(IDX_DATA * 4);
    localparam logic [11:0] A_STAT     = 12'(IDX_STAT * 4);
    localparam logic [11:0] A_MASK     = 12'(IDX_MASK * 4);
    // Control register fields
    localparam int unsigned B_EN       = 7;
    localparam int unsigned B_ACKO     = 6;
    localparam int unsigned B_FLAG     = 5;
    localparam int unsigned B_ACKR     = 4;
    localparam int unsigned B_STOP     = 2;
    localparam int unsigned B_DIV_HI   = 1;
    localparam logic [7:0]  CTRL_RST   = 8'h04;
    localparam logic [7:0]  DATA_RST   = 8'h00;
    // Last count of one quarter of a bus clock period per divisor
    localparam logic [5:0]  QTR_DIV4   = 6'h00;
    localparam logic [5:0]  QTR_DIV16  = 6'h03;
    localparam logic [5:0]  QTR_DIV64  = 6'h0f;
    localparam logic [5:0]  QTR_DIV256 = 6'h3f;
    // Bit sequencing
    localparam logic [3:0]  ACK_SLOT   = 4'h8;
    localparam logic [1:0]  PH_HIGH    = 2'h2;
    localparam logic [1:0]  PH_LAST    = 2'h3;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLV   = 2'h2;
    // Controller states
    typedef enum logic [2:0] {S_IDLE, S_START, S_WAIT, S_XFER, S_STOP} state_t;
endpackage

// ==== master_two_wire_controller.sv ====
// Master two-wire serial controller with AXI4-Lite register access
//
// Contract
// RQ1: Controller acts only while enable bit set
// RQ2: Received byte acknowledged with ack_to_send value
// RQ3: Byte completion sets byte_done_flag
// RQ4: Writing zero clears byte_done_flag, else sticky
// RQ5: Slave acknowledge reported, zero ACK one NACK
// RQ6: Stop bit at position 2 resets to one
// RQ7: Bus clock is system clock divided 4..256
// RQ8: Data write after start resumes transmission
// RQ9: Data read after start resumes reception
// RQ10: Slaves follow standard two-wire protocol
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module master_two_wire_controller
    import two_wire_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // AXI4-Lite write channels
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read channels
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Open-drain bus lines, enable high pulls low
    output logic                   scl_oe,
    input  wire logic              sda_i,
    output logic                   sda_oe,
    // Interrupt
    output logic                   irq
);
    state_t      state_q, state_d;     // Bus sequencer state
    logic [5:0]  cnt_q, cnt_d;         // Quarter period counter
    logic [1:0]  phase_q, phase_d;     // Quarter within a bit
    logic [3:0]  bit_q, bit_d;         // Bit slot, eight is acknowledge
    logic        tx_q, tx_d;           // Byte direction, one transmits
    logic [7:0]  shift_q, shift_d;     // Data shift register
    logic        en_q, en_d;           // Controller enable
    logic        acko_q, acko_d;       // Acknowledge to send
    logic        flag_q, flag_d;       // Byte done flag
    logic        ackr_q, ackr_d;       // Acknowledge received
    logic        stop_q, stop_d;       // Stop condition bit
    logic [1:0]  div_q, div_d;         // Bus clock divisor select
    logic        stat_q, stat_d;       // Sticky interrupt status
    logic        mask_q, mask_d;       // Interrupt mask
    logic        scl_q, scl_d;         // Clock line pull-down
    logic        sda_q, sda_d;         // Data line pull-down
    logic        aw_q, aw_d;           // Write address held
    logic        w_q, w_d;             // Write data held
    logic [11:0] wa_q, wa_d;           // Held write address
    logic [7:0]  wd_q, wd_d;           // Held write data low byte
    logic        ws_q, ws_d;           // Held low byte strobe
    logic        bv_q, bv_d;           // Write response valid
    logic [1:0]  br_q, br_d;           // Write response code
    logic        rv_q, rv_d;           // Read response valid
    logic [7:0]  rd_q, rd_d;           // Read data
    logic [1:0]  rr_q, rr_d;           // Read response code
    logic [5:0]  qlast;                // Last count of a quarter
    logic        tick;                 // Quarter boundary
    logic        wr_go;                // Held write performed
    logic        rd_go;                // Read address taken
    logic        bit_end;              // End of one bit slot

    // Handshake outputs and derived strobes
    always_comb
    begin
        awready = !aw_q && !bv_q;
        wready  = !w_q && !bv_q;
        arready = !rv_q;
        wr_go   = aw_q && w_q && !bv_q;
        rd_go   = arvalid && !rv_q;
        case (div_q)
            2'h0:    qlast = QTR_DIV4;
            2'h1:    qlast = QTR_DIV16;
            2'h2:    qlast = QTR_DIV64;
            default: qlast = QTR_DIV256;
        endcase
        tick    = (cnt_q == qlast); // RQ7
        bit_end = tick && (phase_q == PH_LAST);
    end

    // Next values of bus slave, registers and sequencer
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        phase_d = phase_q;
        bit_d   = bit_q;
        tx_d    = tx_q;
        shift_d = shift_q;
        en_d    = en_q;
        acko_d  = acko_q;
        flag_d  = flag_q;
        ackr_d  = ackr_q;
        stop_d  = stop_q;
        div_d   = div_q;
        stat_d  = stat_q;
        mask_d  = mask_q;
        aw_d    = aw_q || (awvalid && awready);
        w_d     = w_q || (wvalid && wready);
        wa_d    = (awvalid && awready) ? awaddr : wa_q;
        wd_d    = (wvalid && wready) ? wdata[7:0] : wd_q;
        ws_d    = (wvalid && wready) ? wstrb[0] : ws_q;
        bv_d    = bv_q && !bready;
        br_d    = br_q;
        rv_d    = rv_q && !rready;
        rd_d    = rd_q;
        rr_d    = rr_q;
        // Quarter timing runs only in start, transfer and stop
        if (state_q == S_IDLE || state_q == S_WAIT)
        begin
            cnt_d   = '0;
            phase_d = '0;
        end
        else if (tick)
        begin
            cnt_d   = '0;
            phase_d = phase_q + 2'h1;
        end
        else
        begin
            cnt_d = cnt_q + 6'h01;
        end
        // Register writes take effect once address and data are held
        if (wr_go)
        begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            bv_d = 1'b1;
            br_d = RESP_OKAY;
            if (wa_q == A_CTRL && ws_q)
            begin
                en_d   = wd_q[B_EN];
                acko_d = wd_q[B_ACKO];
                stop_d = wd_q[B_STOP];
                div_d  = wd_q[B_DIV_HI:0];
                if (!wd_q[B_FLAG])
                    flag_d = 1'b0; // RQ4
                // Clearing stop while idle and already enabled opens a frame
                if (state_q == S_IDLE && en_q && !wd_q[B_STOP])
                    state_d = S_START;
                // Setting stop between bytes closes the frame
                if (state_q == S_WAIT && wd_q[B_STOP])
                    state_d = S_STOP;
            end
            else if (wa_q == A_DATA && ws_q)
            begin
                if (state_q != S_XFER)
                    shift_d = wd_q;
                if (state_q == S_WAIT)
                begin
                    state_d = S_XFER; // RQ8
                    tx_d    = 1'b1;
                    bit_d   = '0;
                end
            end
            else if (wa_q == A_MASK && ws_q)
            begin
                mask_d = wd_q[0];
            end
            else if (wa_q != A_CTRL && wa_q != A_DATA && wa_q != A_STAT && wa_q != A_MASK)
            begin
                br_d = RESP_SLV;
            end
        end
        // Register reads, some with side effects
        if (rd_go)
        begin
            rv_d = 1'b1;
            rr_d = RESP_OKAY;
            rd_d = '0;
            case (araddr)
                A_CTRL:  rd_d = {en_q, acko_q, flag_q, ackr_q, 1'b0, stop_q, div_q}; // RQ6
                A_DATA:
                begin
                    rd_d = shift_q;
                    if (state_q == S_WAIT)
                    begin
                        state_d = S_XFER; // RQ9
                        tx_d    = 1'b0;
                        bit_d   = '0;
                    end
                end
                A_STAT:
                begin
                    rd_d   = {7'h00, stat_q};
                    stat_d = 1'b0;
                end
                A_MASK:  rd_d = {7'h00, mask_q};
                default: rr_d = RESP_SLV;
            endcase
        end
        // Frame sequencing at the end of each bit slot
        if (bit_end)
        begin
            case (state_q)
                S_START: state_d = S_WAIT;
                S_STOP:  state_d = S_IDLE;
                S_XFER:
                begin
                    if (bit_q != ACK_SLOT)
                    begin
                        shift_d = {shift_q[6:0], sda_i};
                        bit_d   = bit_q + 4'h1;
                    end
                    else
                    begin
                        if (tx_q)
                            ackr_d = sda_i; // RQ5
                        flag_d  = 1'b1;     // RQ3
                        stat_d  = 1'b1;
                        bit_d   = '0;
                        state_d = S_WAIT;
                    end
                end
                default: state_d = state_q;
            endcase
        end
        // A disabled controller leaves the bus alone
        if (!en_q)
            state_d = S_IDLE; // RQ1
        // Line drive, one clock behind the sequencer
        scl_d = 1'b0;
        sda_d = 1'b0;
        case (state_q)
            S_IDLE:  sda_d = 1'b0;
            S_START: sda_d = (phase_q >= PH_HIGH);
            S_WAIT:
            begin
                scl_d = 1'b1;
                sda_d = sda_q;
            end
            S_XFER:
            begin
                scl_d = (phase_q < PH_HIGH);
                if (phase_q == 2'h0)
                    sda_d = sda_q;
                else if (bit_q != ACK_SLOT)
                    sda_d = tx_q && !shift_q[7];
                else
                    sda_d = !tx_q && !acko_q; // RQ2
            end
            S_STOP:
            begin
                scl_d = (phase_q < PH_HIGH);
                sda_d = (phase_q != PH_LAST);
            end
            default: sda_d = 1'b0;
        endcase
    end

    // State registers
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            state_q <= S_IDLE;
            cnt_q   <= '0;
            phase_q <= '0;
            bit_q   <= '0;
            tx_q    <= 1'b0;
            shift_q <= DATA_RST;
            en_q    <= CTRL_RST[B_EN];
            acko_q  <= CTRL_RST[B_ACKO];
            flag_q  <= CTRL_RST[B_FLAG];
            ackr_q  <= CTRL_RST[B_ACKR];
            stop_q  <= CTRL_RST[B_STOP]; // RQ6
            div_q   <= CTRL_RST[B_DIV_HI:0];
            stat_q  <= 1'b0;
            mask_q  <= 1'b0;
            scl_q   <= 1'b0;
            sda_q   <= 1'b0;
            aw_q    <= 1'b0;
            w_q     <= 1'b0;
            wa_q    <= '0;
            wd_q    <= '0;
            ws_q    <= 1'b0;
            bv_q    <= 1'b0;
            br_q    <= RESP_OKAY;
            rv_q    <= 1'b0;
            rd_q    <= '0;
            rr_q    <= RESP_OKAY;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            phase_q <= phase_d;
            bit_q   <= bit_d;
            tx_q    <= tx_d;
            shift_q <= shift_d;
            en_q    <= en_d;
            acko_q  <= acko_d;
            flag_q  <= flag_d;
            ackr_q  <= ackr_d;
            stop_q  <= stop_d;
            div_q   <= div_d;
            stat_q  <= stat_d;
            mask_q  <= mask_d;
            scl_q   <= scl_d;
            sda_q   <= sda_d;
            aw_q    <= aw_d;
            w_q     <= w_d;
            wa_q    <= wa_d;
            wd_q    <= wd_d;
            ws_q    <= ws_d;
            bv_q    <= bv_d;
            br_q    <= br_d;
            rv_q    <= rv_d;
            rd_q    <= rd_d;
            rr_q    <= rr_d;
        end
    end

    // Output wiring
    assign bvalid = bv_q;
    assign bresp  = br_q;
    assign rvalid = rv_q;
    assign rresp  = rr_q;
    assign rdata  = {24'h000000, rd_q};
    assign scl_oe = scl_q;
    assign sda_oe = sda_q;
    assign irq    = stat_q && mask_q;

    // Checks on the sequencer and register behaviour
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    disabled_idle_a: assert property (!en_q |=> state_q == S_IDLE) // RQ1
        else $error("controller active while disabled");
    ack_drive_a: assert property (state_q == S_XFER && !tx_q && bit_q == ACK_SLOT && phase_q == PH_HIGH // RQ2
        |=> sda_oe == !$past(acko_q))
        else $error("receive acknowledge not from ack_to_send");
    // Sequencer only parks in wait while still enabled
    flag_set_a: assert property (state_q == S_XFER && bit_q == ACK_SLOT && bit_end && en_q // RQ3
        |=> flag_q && stat_q && state_q == S_WAIT)
        else $error("byte completion did not set flag");
    flag_hold_a: assert property (flag_q && !(wr_go && wa_q == A_CTRL && ws_q && !wd_q[B_FLAG]) // RQ4
        |=> flag_q)
        else $error("byte done flag lost without clear");
    ack_report_a: assert property (state_q == S_XFER && tx_q && bit_q == ACK_SLOT && bit_end // RQ5
        |=> ackr_q == $past(sda_i))
        else $error("received acknowledge misreported");
    stop_reset_a: assert property ($rose(resetn) |-> stop_q && div_q == 2'h0) // RQ6
        else $error("stop bit or divisor wrong after reset");
    // The last quarter of a byte hands over to wait, where quarters stop
    quarter_len_a: assert property (state_q == S_XFER && div_q == 2'h1 && tick && en_q // RQ7
        && !(bit_q == ACK_SLOT && phase_q == PH_LAST)
        |=> !tick [*3] ##1 tick)
        else $error("divide by sixteen quarter length wrong");
    tx_resume_a: assert property (wr_go && wa_q == A_DATA && ws_q && state_q == S_WAIT && en_q // RQ8
        |=> state_q == S_XFER && tx_q && shift_q == $past(wd_q))
        else $error("data write did not resume transmission");
    rx_resume_a: assert property (rd_go && araddr == A_DATA && state_q == S_WAIT && en_q // RQ9
        |=> state_q == S_XFER && !tx_q && rvalid)
        else $error("data read did not resume reception");

    byte_tx_c: cover property (state_q == S_XFER && tx_q && bit_q == ACK_SLOT && bit_end);
    byte_rx_c: cover property (state_q == S_XFER && !tx_q && bit_q == ACK_SLOT && bit_end);
    stop_done_c: cover property (state_q == S_STOP && bit_end);
endmodule

// ==== two_wire_slave_model.sv ====
// Behavioural slave device on the two-wire bus
`timescale 1ns/100ps
module two_wire_slave_model
(
    // Bus wire levels
    input  wire logic       scl,
    input  wire logic       sda,
    // Behaviour chosen by the bench
    input  wire logic       rd_mode,
    input  wire logic       nack,
    input  wire logic [7:0] tx_byte,
    // Pull-down and observations
    output logic            sda_pull,
    output logic [7:0]      rx_byte,
    output logic            ack_seen
);
    int   cnt  = -1;   // Bit index within a byte, -1 outside frames
    logic done = 1'b0; // Read byte already sent in this frame

    // Start restarts the count and allows one read byte
    always @(negedge sda)
    begin
        if (scl)
        begin
            cnt  = -1;
            done = 1'b0;
        end
    end

    // Stop ends the frame
    always @(posedge sda)
    begin
        if (scl)
            cnt = -1;
    end

    // Each falling clock opens the next bit, nine to a byte
    always @(negedge scl)
    begin
        cnt = (cnt == 8) ? 0 : cnt + 1;
    end

    // Sample written bits MSB first and the master acknowledge
    always @(posedge scl)
    begin
        if (cnt >= 0 && cnt < 8)
            rx_byte = {rx_byte[6:0], sda};
        else if (cnt == 8 && rd_mode)
        begin
            ack_seen = sda;
            done     = 1'b1;
        end
    end

    // Acknowledge written bytes, drive each read bit from one falling clock to the next
    assign sda_pull = rd_mode ? (cnt >= 0 && cnt < 8 && !done && !tx_byte[7 - cnt])
                              : (cnt == 8 && !nack);
endmodule

// ==== tb_master_two_wire_controller.sv ====
// Self-checking testbench for the master two-wire controller
`timescale 1ns/100ps
module tb_master_two_wire_controller import two_wire_pkg::*;;
    // Bus master side
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0]       wdata = '0, rdata;
    logic [3:0]        wstrb = '0;
    logic [1:0]        bresp, rresp;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    // Clock, reset, lines and slave controls
    logic              clk_sys = 1'b0, resetn = 1'b0;
    logic              scl_oe, sda_oe, sda_pull, irq, ack_seen;
    logic              s_rd = 1'b0, s_nack = 1'b0, prev_oe = 1'b0;
    logic [7:0]        s_tx = '0, rx_byte;
    wire               scl = !scl_oe;              // Released lines pull high
    wire               sda = !(sda_oe || sda_pull);
    // Expected answers and counters
    logic [1:0]        exp_b[$];
    logic [33:0]       exp_r[$], er;
    int                miscompares = 0, comparisons = 0, cyc = 0, last_rise = 0, scl_per = 0;

    master_two_wire_controller master_two_wire_controller_inst (.*, .sda_i(sda));
    two_wire_slave_model two_wire_slave_model_inst (.scl(scl), .sda(sda), .rd_mode(s_rd), .nack(s_nack),
        .tx_byte(s_tx), .sda_pull(sda_pull), .rx_byte(rx_byte), .ack_seen(ack_seen));

    // 250 MHz clock
    always #2 clk_sys = ~clk_sys;

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Register write; waits only on the handshakes
    task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] r);
        logic tb = 1'b0;
        exp_b.push_back(r);
        @(posedge clk_sys);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        wstrb   <= 4'hf;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!tb)
        begin
            @(posedge clk_sys);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            tb = bvalid;
        end
        bready <= 1'b0;
    endtask

    // Register read; the monitor compares the answer
    task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        logic tr = 1'b0;
        exp_r.push_back({r, d});
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        while (!tr)
        begin
            @(posedge clk_sys);
            if (arvalid && arready)
                arvalid <= 1'b0;
            tr = rvalid;
        end
        rready <= 1'b0;
    endtask

    // Bounded wait for the interrupt
    task automatic wait_irq();
        int n = 0;
        while (irq !== 1'b1 && n < 20000)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk("irq", 32'h1, 32'(irq));
    endtask

    // Match each bus answer with the oldest note
    always @(posedge clk_sys)
    begin
        if (bvalid && bready)
            chk("bresp", 32'(exp_b.pop_front()), 32'(bresp));
        if (rvalid && rready)
        begin
            er = exp_r.pop_front();
            chk("rdata", er[31:0], rdata);
            chk("rresp", 32'(er[33:32]), 32'(rresp));
        end
    end

    // Bus clock period from falls of SCL, and the hang limit
    always @(posedge clk_sys)
    begin
        cyc     <= cyc + 1;
        prev_oe <= scl_oe;
        if (scl_oe && !prev_oe)
        begin
            scl_per   <= cyc - last_rise;
            last_rise <= cyc;
        end
        if (cyc == 20000)
        begin
            miscompares++;
            complete_run();
        end
    end

    // Main sequence
    initial
    begin
        logic [7:0] b, t;
        logic       a, k, any;
        void'($urandom(75));
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        axi_rd(A_CTRL, {24'h0, CTRL_RST}, RESP_OKAY);
        axi_rd(A_DATA, {24'h0, DATA_RST}, RESP_OKAY);
        axi_rd(12'h004, 32'h0, RESP_SLV);
        axi_wr(12'h008, 8'hff, RESP_SLV);
        axi_wr(A_MASK, 8'h01, RESP_OKAY);
        axi_rd(A_MASK, 32'h1, RESP_OKAY);
        // Clearing stop while disabled must leave the bus alone
        axi_wr(A_CTRL, 8'h00, RESP_OKAY);
        any = 1'b0;
        repeat (16)
        begin
            @(posedge clk_sys);
            any = any | scl_oe | sda_oe;
        end
        chk("bus idle", 32'h0, 32'(any));
        $display("reset and disable test done");
        for (int d = 0; d < 4; d++)
        begin
            b = 8'($urandom);
            t = 8'($urandom);
            a = d[0];
            k = d[1];
            s_rd   <= 1'b0;
            s_nack <= k;
            // Start, then send one byte
            axi_wr(A_CTRL, {6'h21, 2'(d)}, RESP_OKAY);
            axi_wr(A_CTRL, {6'h20, 2'(d)}, RESP_OKAY);
            // Start takes one bit time; a data write before wait would not resume
            repeat (4 << (2 * d)) @(posedge clk_sys);
            axi_wr(A_DATA, b, RESP_OKAY);
            wait_irq();
            axi_rd(A_STAT, 32'h1, RESP_OKAY);
            repeat (2) @(posedge clk_sys);
            chk("irq cleared", 32'h0, 32'(irq));
            chk("slave byte", 32'(b), 32'(rx_byte));
            chk("scl period", 32'(4 << (2 * d)), 32'(scl_per));
            axi_rd(A_CTRL, {24'h0, 3'b101, k, 2'b00, 2'(d)}, RESP_OKAY);
            axi_wr(A_CTRL, {1'b1, a, 4'h0, 2'(d)}, RESP_OKAY);
            axi_rd(A_CTRL, {24'h0, 1'b1, a, 1'b0, k, 2'b00, 2'(d)}, RESP_OKAY);
            // Receive one byte, masked once
            s_rd <= 1'b1;
            s_tx <= t;
            axi_wr(A_MASK, {7'h0, d != 2}, RESP_OKAY);
            axi_rd(A_DATA, 32'(b), RESP_OKAY);
            if (d == 2)
            begin
                repeat (40 * (1 << (2 * d))) @(posedge clk_sys);
                chk("irq masked", 32'h0, 32'(irq));
                axi_wr(A_MASK, 8'h01, RESP_OKAY);
            end
            wait_irq();
            axi_rd(A_STAT, 32'h1, RESP_OKAY);
            axi_wr(A_CTRL, {1'b1, a, 4'h1, 2'(d)}, RESP_OKAY);
            repeat (8 * (1 << (2 * d)) + 4) @(posedge clk_sys);
            axi_rd(A_DATA, 32'(t), RESP_OKAY);
            chk("master ack", 32'(a), 32'(ack_seen));
            $display("divisor %0d test done", d);
        end
        complete_run();
    end
endmodule
